// file: hdl/muxed_bidir_io_port.sv
// Overview of operation
// RULE1: Eight pins, each usable as input or output under software control.
// RULE2: Each pin's direction comes from its own direction register bit.
// RULE3: Some enabled peripherals force their pin to output, others to input.
// RULE4: The override lasts as long as the peripheral stays enabled.
// RULE5: Software avoids read-modify-write of direction while overrides are active.
// RULE6: A peripheral output enable reaches a pin only while its select is active.
// RULE7: Larger variants: pin 0 is I/O, timer oscillator output or clock input.
// RULE8: Smallest variant: pin 0 oscillator/clock input, pin 1 oscillator output.
// RULE9: Largest variants: pin 1 is I/O, oscillator input or second capture/compare/PWM.
// RULE10: Pin 2 is I/O or first capture input, compare or PWM output.
// RULE11: Pin 3 serves as serial clock in SPI and I2C modes.
// RULE12: Pin 4 is SPI data input or I2C bidirectional data line.
// RULE13: Pin 5 is I/O or serial port data output.
// RULE14: With USART, pin 6 is I/O, asynchronous transmit or synchronous clock.
// RULE15: With USART, pin 7 is I/O, asynchronous receive or synchronous data.
// RULE16: Data reads return pin levels; writes load the output latch.
`timescale 1ns/1ns
`default_nettype none
module muxed_bidir_io_port #(
  parameter port_pkg::variant_t VARIANT = port_pkg::VAR_LARGE
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output var  logic [7:0] rdData,
  // Pads
  input  wire logic [7:0] pinIn,
  output var  logic [7:0] pinOut,
  output var  logic [7:0] pinOe,
  // Timer oscillator and clock input
  input  wire logic       timerOscEnable,
  input  wire logic       timerOscDrive,
  input  wire logic       timerExtClockEnable,
  output var  logic       timerOscIn,
  output var  logic       timerExtClockIn,
  // Capture/compare/PWM units
  input  wire logic       ccpOneEnable,
  input  wire logic       ccpOneOutputMode,
  input  wire logic       ccpOneDrive,
  output var  logic       ccpOneIn,
  input  wire logic       ccpTwoEnable,
  input  wire logic       ccpTwoOutputMode,
  input  wire logic       ccpTwoDrive,
  output var  logic       ccpTwoIn,
  // Synchronous serial port
  input  wire logic       sspEnable,
  input  wire logic       sspI2cMode,
  input  wire logic       sspSpiMaster,
  input  wire logic       sspClockDrive,
  input  wire logic       sspDataDrive,
  output var  logic       serialClockIn,
  output var  logic       serialDataIn,
  // USART
  input  wire logic       usartEnable,
  input  wire logic       usartSyncMode,
  input  wire logic       usartSyncMaster,
  input  wire logic       usartTxClockDrive,
  input  wire logic       usartDataDrive,
  input  wire logic       usartDataOe,
  output var  logic       usartClockIn,
  output var  logic       usartReceiveOrDataIn
);

  localparam logic HAS_CCP_TWO = (VARIANT == port_pkg::VAR_LARGE);
  localparam logic HAS_USART   = (VARIANT == port_pkg::VAR_LARGE);

  // Software-visible state
  logic [7:0] dataLatch;
  logic [7:0] direction;

  // Per-pin peripheral steering
  logic [7:0] periphSelect;
  logic [7:0] periphDrive;
  logic [7:0] forceOut;
  logic [7:0] forceIn;
  logic [7:0] effDirection;
  logic [7:0] next_pinOut;

  // Decoded accesses
  logic       hitData;
  logic       hitDir;

  assign hitData = (addr == port_pkg::ADDR_PORT_DATA);
  assign hitDir  = (addr == port_pkg::ADDR_PORT_DIR);

  // Output latch; pins only see it while they are outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dataLatch <= port_pkg::RESET_PORT_DATA;
    end else if (wrStrobe && hitData) begin
      dataLatch <= wrData; // RULE16
    end
  end

  // Direction register, all inputs after reset so no pin fights the board
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      direction <= port_pkg::RESET_PORT_DIR;
    end else if (wrStrobe && hitDir) begin
      direction <= wrData; // RULE2
    end
  end

  // Timer oscillator pins swap roles between variants
  logic [7:0] tmSel;
  logic [7:0] tmDrv;
  logic [7:0] tmOut;
  logic [7:0] tmIn;

  always_comb begin
    tmSel = port_pkg::ALL_CLEAR;
    tmDrv = port_pkg::ALL_CLEAR;
    tmOut = port_pkg::ALL_CLEAR;
    tmIn  = port_pkg::ALL_CLEAR;
    case (VARIANT)
      port_pkg::VAR_SMALL: begin
        if (timerOscEnable) begin
          tmIn[port_pkg::PIN_TIMER_A]  = 1'b1; // RULE8
          tmSel[port_pkg::PIN_TIMER_B] = 1'b1; // RULE8
          tmOut[port_pkg::PIN_TIMER_B] = 1'b1; // RULE8
          tmDrv[port_pkg::PIN_TIMER_B] = timerOscDrive;
        end else if (timerExtClockEnable) begin
          tmIn[port_pkg::PIN_TIMER_A] = 1'b1; // RULE8
        end
      end
      port_pkg::VAR_MID,
      port_pkg::VAR_LARGE: begin
        if (timerOscEnable) begin
          tmIn[port_pkg::PIN_TIMER_B]  = 1'b1; // RULE9
          tmSel[port_pkg::PIN_TIMER_A] = 1'b1; // RULE7
          tmOut[port_pkg::PIN_TIMER_A] = 1'b1; // RULE7
          tmDrv[port_pkg::PIN_TIMER_A] = timerOscDrive;
        end else if (timerExtClockEnable) begin
          tmIn[port_pkg::PIN_TIMER_A] = 1'b1; // RULE7
        end
      end
      default: begin
        tmSel = port_pkg::ALL_CLEAR;
      end
    endcase
  end

  // Capture/compare/PWM; the oscillator wins pin 1 when both want it
  logic [7:0] ccSel;
  logic [7:0] ccDrv;
  logic [7:0] ccOut;
  logic [7:0] ccIn;

  always_comb begin
    ccSel = port_pkg::ALL_CLEAR;
    ccDrv = port_pkg::ALL_CLEAR;
    ccOut = port_pkg::ALL_CLEAR;
    ccIn  = port_pkg::ALL_CLEAR;
    if (ccpOneEnable) begin
      if (ccpOneOutputMode) begin
        ccSel[port_pkg::PIN_CCP_ONE] = 1'b1; // RULE10
        ccOut[port_pkg::PIN_CCP_ONE] = 1'b1; // RULE3
        ccDrv[port_pkg::PIN_CCP_ONE] = ccpOneDrive;
      end else begin
        ccIn[port_pkg::PIN_CCP_ONE] = 1'b1; // RULE10
      end
    end
    if (HAS_CCP_TWO && ccpTwoEnable && !timerOscEnable) begin
      if (ccpTwoOutputMode) begin
        ccSel[port_pkg::PIN_TIMER_B] = 1'b1; // RULE9
        ccOut[port_pkg::PIN_TIMER_B] = 1'b1; // RULE3
        ccDrv[port_pkg::PIN_TIMER_B] = ccpTwoDrive;
      end else begin
        ccIn[port_pkg::PIN_TIMER_B] = 1'b1; // RULE9
      end
    end
  end

  // Serial port; in I2C mode the lines stay under the direction bits
  logic [7:0] ssSel;
  logic [7:0] ssDrv;
  logic [7:0] ssOut;
  logic [7:0] ssIn;

  always_comb begin
    ssSel = port_pkg::ALL_CLEAR;
    ssDrv = port_pkg::ALL_CLEAR;
    ssOut = port_pkg::ALL_CLEAR;
    ssIn  = port_pkg::ALL_CLEAR;
    if (sspEnable) begin
      if (sspI2cMode) begin
        // Open drain: drive low only, release by setting the direction bit
        ssSel[port_pkg::PIN_SER_CLOCK] = 1'b1; // RULE11
        ssSel[port_pkg::PIN_SER_DIN]   = 1'b1; // RULE12
        ssDrv[port_pkg::PIN_SER_CLOCK] = port_pkg::I2C_DRIVE_LEVEL;
        ssDrv[port_pkg::PIN_SER_DIN]   = port_pkg::I2C_DRIVE_LEVEL;
      end else begin
        ssIn[port_pkg::PIN_SER_DIN]   = 1'b1; // RULE12
        ssSel[port_pkg::PIN_SER_DOUT] = 1'b1; // RULE13
        ssOut[port_pkg::PIN_SER_DOUT] = 1'b1; // RULE13
        ssDrv[port_pkg::PIN_SER_DOUT] = sspDataDrive;
        if (sspSpiMaster) begin
          ssSel[port_pkg::PIN_SER_CLOCK] = 1'b1; // RULE11
          ssOut[port_pkg::PIN_SER_CLOCK] = 1'b1; // RULE11
          ssDrv[port_pkg::PIN_SER_CLOCK] = sspClockDrive;
        end else begin
          ssIn[port_pkg::PIN_SER_CLOCK] = 1'b1; // RULE11
        end
      end
    end
  end

  // USART, present on the largest variant only
  logic [7:0] usSel;
  logic [7:0] usDrv;
  logic [7:0] usOut;
  logic [7:0] usIn;

  always_comb begin
    usSel = port_pkg::ALL_CLEAR;
    usDrv = port_pkg::ALL_CLEAR;
    usOut = port_pkg::ALL_CLEAR;
    usIn  = port_pkg::ALL_CLEAR;
    if (HAS_USART && usartEnable) begin
      if (!usartSyncMode) begin
        usSel[port_pkg::PIN_USART_TX] = 1'b1; // RULE14
        usOut[port_pkg::PIN_USART_TX] = 1'b1; // RULE14
        usDrv[port_pkg::PIN_USART_TX] = usartTxClockDrive;
        usIn[port_pkg::PIN_USART_RX]  = 1'b1; // RULE15
      end else begin
        if (usartSyncMaster) begin
          usSel[port_pkg::PIN_USART_TX] = 1'b1; // RULE14
          usOut[port_pkg::PIN_USART_TX] = 1'b1; // RULE14
          usDrv[port_pkg::PIN_USART_TX] = usartTxClockDrive;
        end else begin
          usIn[port_pkg::PIN_USART_TX] = 1'b1; // RULE14
        end
        if (usartDataOe) begin
          usSel[port_pkg::PIN_USART_RX] = 1'b1; // RULE15
          usOut[port_pkg::PIN_USART_RX] = 1'b1; // RULE15
          usDrv[port_pkg::PIN_USART_RX] = usartDataDrive;
        end else begin
          usIn[port_pkg::PIN_USART_RX] = 1'b1; // RULE15
        end
      end
    end
  end

  // Functions own disjoint pins, so plain OR merges them
  assign periphSelect = tmSel | ccSel | ssSel | usSel;
  assign periphDrive  = tmDrv | ccDrv | ssDrv | usDrv;
  assign forceOut     = (tmOut | ccOut | ssOut | usOut) & periphSelect; // RULE6
  assign forceIn      = tmIn | ccIn | ssIn | usIn;

  // Override holds only while the peripheral enable holds; no state kept
  always_comb begin
    for (int i = 0; i < port_pkg::PORT_WIDTH; i++) begin
      if (forceOut[i]) begin
        effDirection[i] = port_pkg::DIR_OUTPUT; // RULE3 RULE4
      end else if (forceIn[i]) begin
        effDirection[i] = port_pkg::DIR_INPUT; // RULE3 RULE4
      end else begin
        effDirection[i] = direction[i]; // RULE1 RULE2
      end
      next_pinOut[i] = periphSelect[i] ? periphDrive[i] : dataLatch[i];
    end
  end

  // Pad drivers registered to keep the outputs glitch free
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pinOut <= port_pkg::RESET_PORT_DATA;
      pinOe  <= port_pkg::ALL_CLEAR;
    end else begin
      pinOut <= next_pinOut; // RULE16
      pinOe  <= ~effDirection; // RULE1 RULE6
    end
  end

  // Register read; direction reads back the overridden value, which is
  // why read-modify-write on it can corrupt stored bits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= port_pkg::READ_UNMAPPED;
    end else if (rdStrobe && hitData) begin
      rdData <= pinIn; // RULE16
    end else if (rdStrobe && hitDir) begin
      rdData <= effDirection; // RULE5
    end else begin
      rdData <= port_pkg::READ_UNMAPPED;
    end
  end

  // Pin levels handed to the timer inputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timerOscIn      <= 1'b0;
      timerExtClockIn <= 1'b0;
    end else begin
      if (VARIANT == port_pkg::VAR_SMALL) begin
        timerOscIn <= pinIn[port_pkg::PIN_TIMER_A]; // RULE8
      end else begin
        timerOscIn <= pinIn[port_pkg::PIN_TIMER_B]; // RULE9
      end
      timerExtClockIn <= pinIn[port_pkg::PIN_TIMER_A]; // RULE7
    end
  end

  // Capture inputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ccpOneIn <= 1'b0;
      ccpTwoIn <= 1'b0;
    end else begin
      ccpOneIn <= pinIn[port_pkg::PIN_CCP_ONE]; // RULE10
      ccpTwoIn <= HAS_CCP_TWO & pinIn[port_pkg::PIN_TIMER_B]; // RULE9
    end
  end

  // Serial port inputs; I2C lines are read back even while driven low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      serialClockIn <= 1'b0;
      serialDataIn  <= 1'b0;
    end else begin
      serialClockIn <= pinIn[port_pkg::PIN_SER_CLOCK]; // RULE11
      serialDataIn  <= pinIn[port_pkg::PIN_SER_DIN]; // RULE12
    end
  end

  // USART inputs, held low on variants without a USART
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      usartClockIn         <= 1'b0;
      usartReceiveOrDataIn <= 1'b0;
    end else begin
      usartClockIn         <= HAS_USART & pinIn[port_pkg::PIN_USART_TX]; // RULE14
      usartReceiveOrDataIn <= HAS_USART & pinIn[port_pkg::PIN_USART_RX]; // RULE15
    end
  end

endmodule : muxed_bidir_io_port
`default_nettype wire

// file: include/port_pkg.sv
`default_nettype none
package port_pkg;

  // Register addresses on the plain register port
  localparam logic [7:0] ADDR_PORT_DATA = 8'h07;
  localparam logic [7:0] ADDR_PORT_DIR  = 8'h87;

  // Reset values; a one in the direction register means input
  localparam logic [7:0] RESET_PORT_DIR  = 8'hff;
  localparam logic [7:0] RESET_PORT_DATA = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;
  localparam logic [7:0] ALL_CLEAR       = 8'h00;

  // Direction bit encoding
  localparam logic DIR_INPUT  = 1'b1;
  localparam logic DIR_OUTPUT = 1'b0;

  // Level driven on the open-drain serial lines in I2C mode
  localparam logic I2C_DRIVE_LEVEL = 1'b0;

  // Port width
  localparam int PORT_WIDTH = 8;

  // Pin positions of the shared functions
  localparam int PIN_TIMER_A   = 0;
  localparam int PIN_TIMER_B   = 1;
  localparam int PIN_CCP_ONE   = 2;
  localparam int PIN_SER_CLOCK = 3;
  localparam int PIN_SER_DIN   = 4;
  localparam int PIN_SER_DOUT  = 5;
  localparam int PIN_USART_TX  = 6;
  localparam int PIN_USART_RX  = 7;

  // Device variants: pin 0/1 timer roles and extra functions differ
  typedef enum logic [2:0] {
    VAR_SMALL = 3'b001,
    VAR_MID   = 3'b010,
    VAR_LARGE = 3'b100
  } variant_t;

endpackage : port_pkg
`default_nettype wire

// file: sim/muxed_bidir_io_port_chk.sv
`timescale 1ns/1ns
`default_nettype none
module muxed_bidir_io_port_chk #(
  parameter port_pkg::variant_t VARIANT = port_pkg::VAR_LARGE
) (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic [7:0] addr,
  input wire logic       rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic       ccpOneEnable,
  input wire logic       ccpOneOutputMode,
  input wire logic       ccpOneDrive,
  input wire logic       sspEnable,
  input wire logic       sspI2cMode,
  input wire logic       usartEnable,
  input wire logic       usartSyncMode,
  input wire logic       usartTxClockDrive,
  input wire logic       serialDataIn
);
  // Usart pins exist only on the large variant
  localparam bit LARGE = (VARIANT == port_pkg::VAR_LARGE);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_rd_idle: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
    else $error("read data not idle");
  chk_rd_pins: assert property (rdStrobe && addr == port_pkg::ADDR_PORT_DATA |=> rdData == $past(pinIn))
    else $error("data read is not pin level");
  chk_rd_unmapped: assert property (rdStrobe && addr != port_pkg::ADDR_PORT_DATA
    && addr != port_pkg::ADDR_PORT_DIR |=> rdData == port_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");
  chk_usart_async: assert property (LARGE && usartEnable && !usartSyncMode
    |=> pinOe[7:6] == 2'b01 && pinOut[6] == $past(usartTxClockDrive))
    else $error("usart async pins wrong");
  chk_ccp_out: assert property (ccpOneEnable && ccpOneOutputMode |=> pinOe[2] && pinOut[2] == $past(ccpOneDrive))
    else $error("ccp output pin wrong");
  chk_ccp_hold: assert property ((ccpOneEnable && !ccpOneOutputMode) [*2] |-> !pinOe[2])
    else $error("capture pin driven");
  chk_i2c_low: assert property (sspEnable && sspI2cMode |=> pinOut[4:3] == 2'b00)
    else $error("i2c lines not low");
  chk_spi_pins: assert property (sspEnable && !sspI2cMode |=> !pinOe[4] && pinOe[5])
    else $error("spi data pins wrong");
  chk_serial_in: assert property (1'b1 |=> serialDataIn == $past(pinIn[4]))
    else $error("serial data input wrong");

  cover property (rdStrobe && addr == port_pkg::ADDR_PORT_DIR);
  cover property (sspEnable && sspI2cMode);
  cover property (usartEnable && usartSyncMode);
endmodule : muxed_bidir_io_port_chk

bind muxed_bidir_io_port muxed_bidir_io_port_chk #(.VARIANT(VARIANT)) chk_u (
  .clock(clock), .rst_b(rst_b), .addr(addr), .rdStrobe(rdStrobe), .rdData(rdData),
  .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .ccpOneEnable(ccpOneEnable),
  .ccpOneOutputMode(ccpOneOutputMode), .ccpOneDrive(ccpOneDrive), .sspEnable(sspEnable),
  .sspI2cMode(sspI2cMode), .usartEnable(usartEnable), .usartSyncMode(usartSyncMode),
  .usartTxClockDrive(usartTxClockDrive), .serialDataIn(serialDataIn)
);
`default_nettype wire

// file: sim/board_model.sv
`timescale 1ns/1ns
`default_nettype none
module board_model (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] boardLevel,
  input  wire logic [7:0] boardDrive,
  output wire logic [7:0] pinIn
);
  // Device drive wins, then the board; pull-ups hold released lines high
  assign pinIn = (pinOe & pinOut) | (~pinOe & boardDrive & boardLevel) | (~pinOe & ~boardDrive);
endmodule : board_model
`default_nettype wire

// file: sim/muxed_bidir_io_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module muxed_bidir_io_port_tb;
  logic        clock;
  logic        rst_b;
  logic [7:0]  addr;
  logic [7:0]  wrData;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [7:0]  rdData;
  wire  [7:0]  pinIn;
  logic [7:0]  pinOut;
  logic [7:0]  pinOe;
  logic [7:0]  boardLevel;
  logic [7:0]  boardDrive;
  logic [19:0] per;
  wire  [7:0]  perIn;
  logic [7:0]  smallOut;
  logic [7:0]  smallOe;
  wire  [7:0]  smallPinIn;
  wire  [7:0]  smallPerIn;
  int          errors;
  int          check_count;
  int          cycles;

  // Peripheral inputs land at the bit of their pin; bit 5 carries the pin 1 copy
  muxed_bidir_io_port dut_u (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .timerOscEnable(per[19]), .timerOscDrive(per[18]), .timerExtClockEnable(per[17]),
    .timerOscIn(perIn[1]), .timerExtClockIn(perIn[0]), .ccpOneEnable(per[16]),
    .ccpOneOutputMode(per[15]), .ccpOneDrive(per[14]), .ccpOneIn(perIn[2]), .ccpTwoEnable(per[13]),
    .ccpTwoOutputMode(per[12]), .ccpTwoDrive(per[11]), .ccpTwoIn(perIn[5]), .sspEnable(per[10]),
    .sspI2cMode(per[9]), .sspSpiMaster(per[8]), .sspClockDrive(per[7]), .sspDataDrive(per[6]),
    .serialClockIn(perIn[3]), .serialDataIn(perIn[4]), .usartEnable(per[5]), .usartSyncMode(per[4]),
    .usartSyncMaster(per[3]), .usartTxClockDrive(per[2]), .usartDataDrive(per[1]),
    .usartDataOe(per[0]), .usartClockIn(perIn[6]), .usartReceiveOrDataIn(perIn[7])
  );
  board_model board_u (.pinOut(pinOut), .pinOe(pinOe), .boardLevel(boardLevel),
    .boardDrive(boardDrive), .pinIn(pinIn));

  // Smallest variant beside it: timer pins swap, no second capture unit, no USART
  muxed_bidir_io_port #(.VARIANT(port_pkg::VAR_SMALL)) small_u (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(), .pinIn(smallPinIn), .pinOut(smallOut), .pinOe(smallOe),
    .timerOscEnable(per[19]), .timerOscDrive(per[18]), .timerExtClockEnable(per[17]),
    .timerOscIn(smallPerIn[1]), .timerExtClockIn(smallPerIn[0]), .ccpOneEnable(per[16]),
    .ccpOneOutputMode(per[15]), .ccpOneDrive(per[14]), .ccpOneIn(smallPerIn[2]), .ccpTwoEnable(per[13]),
    .ccpTwoOutputMode(per[12]), .ccpTwoDrive(per[11]), .ccpTwoIn(smallPerIn[5]), .sspEnable(per[10]),
    .sspI2cMode(per[9]), .sspSpiMaster(per[8]), .sspClockDrive(per[7]), .sspDataDrive(per[6]),
    .serialClockIn(smallPerIn[3]), .serialDataIn(smallPerIn[4]), .usartEnable(per[5]),
    .usartSyncMode(per[4]), .usartSyncMaster(per[3]), .usartTxClockDrive(per[2]),
    .usartDataDrive(per[1]), .usartDataOe(per[0]), .usartClockIn(smallPerIn[6]),
    .usartReceiveOrDataIn(smallPerIn[7])
  );
  board_model small_board_u (.pinOut(smallOut), .pinOe(smallOe), .boardLevel(boardLevel),
    .boardDrive(boardDrive), .pinIn(smallPinIn));

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Whole-byte writes only, never read-modify-write of the direction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wrStrobe <= 1'b1;
    addr     <= a;
    wrData   <= d;
    @(posedge clock);
    wrStrobe <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rdStrobe <= 1'b1;
    addr     <= a;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1 chk(rdData, exp);
  endtask : rd

  // Set peripherals, board drive and direction, let pins settle
  task automatic cfg(input logic [19:0] p, input logic [7:0] dir, input logic [7:0] drv, input logic [7:0] oe);
    @(posedge clock);
    per        <= p;
    boardDrive <= drv;
    wr(port_pkg::ADDR_PORT_DIR, dir);
    repeat (3) @(posedge clock);
    #1 chk(pinOe, oe);
  endtask : cfg

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Hang guard, far above the roughly 140 cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    per = 20'h00000;
    boardLevel = 8'h95;
    boardDrive = 8'hff;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1 chk(pinOe, 8'h00);
    rd(port_pkg::ADDR_PORT_DIR, port_pkg::RESET_PORT_DIR);
    rd(port_pkg::ADDR_PORT_DATA, 8'h95);
    rd(8'h10, port_pkg::READ_UNMAPPED);
    wr(8'h10, 8'h00);
    rd(port_pkg::ADDR_PORT_DIR, 8'hff);
    wr(port_pkg::ADDR_PORT_DATA, 8'ha5);
    cfg(20'h00000, 8'h00, 8'h00, 8'hff);
    chk(pinOut, 8'ha5);
    rd(port_pkg::ADDR_PORT_DATA, 8'ha5);
    cfg(20'h00000, 8'h5a, 8'h5a, 8'ha5);
    rd(port_pkg::ADDR_PORT_DATA, (8'ha5 & ~8'h5a) | (8'h95 & 8'h5a));
    cfg(20'h00024, 8'h00, 8'h80, 8'h7f);
    chk(pinOut & 8'h40, 8'h40);
    chk(perIn & 8'h80, 8'h80);
    chk(smallOe, 8'hff);
    chk(smallPerIn & 8'hc0, 8'h00);
    rd(port_pkg::ADDR_PORT_DIR, 8'h80);
    cfg(20'h00030, 8'h00, 8'hc0, 8'h3f);
    chk(perIn & 8'hc0, 8'h80);
    cfg(20'h0003b, 8'h00, 8'h00, 8'hff);
    chk(pinOut & 8'hc0, 8'h80);
    cfg(20'h00000, 8'hff, 8'hff, 8'h00);
    chk(perIn, 8'h95);
    cfg(20'h1c000, 8'hff, 8'hfb, 8'h04);
    chk(pinOut & 8'h04, 8'h04);
    cfg(20'h10000, 8'h00, 8'h04, 8'hfb);
    chk(perIn & 8'h04, 8'h04);
    cfg(20'h005c0, 8'hff, 8'hd7, 8'h28);
    chk(pinOut & 8'h28, 8'h28);
    chk(perIn & 8'h10, 8'h10);
    cfg(20'h00600, 8'he7, 8'he7, 8'h18);
    chk(pinOut & 8'h18, 8'h00);
    cfg(20'hc0000, 8'hff, 8'hfe, 8'h01);
    chk(pinOut & 8'h01, 8'h01);
    chk(perIn & 8'h02, 8'h00);
    chk(smallOe, 8'h02);
    chk(smallOut & 8'h02, 8'h02);
    chk(smallPerIn & 8'h03, 8'h03);
    cfg(20'hc3800, 8'hff, 8'hfe, 8'h01);
    cfg(20'h03800, 8'hff, 8'hfd, 8'h02);
    chk(pinOut & 8'h02, 8'h02);
    chk(perIn & 8'h20, 8'h20);
    chk(smallOe, 8'h00);
    chk(smallPerIn & 8'h20, 8'h00);
    cfg(20'h20000, 8'h00, 8'h01, 8'hfe);
    chk(perIn & 8'h01, 8'h01);
    cfg(20'h00000, 8'h00, 8'h00, 8'hff);
    // Inverted board levels so no peripheral input can pass stuck at one value
    @(posedge clock);
    boardLevel <= 8'h6a;
    cfg(20'h00000, 8'hff, 8'hff, 8'h00);
    chk(perIn, 8'h6a);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1 chk(pinOe, 8'h00);
    rd(port_pkg::ADDR_PORT_DIR, port_pkg::RESET_PORT_DIR);
    cfg(20'h00000, 8'h00, 8'h00, 8'hff);
    chk(pinOut, port_pkg::RESET_PORT_DATA);
    stop_test();
  end
endmodule : muxed_bidir_io_port_tb
`default_nettype wire
